// ==== hw/timer_pkg.sv ====
// constants shared by the five-channel timer block
package timer_pkg;
	localparam int NUM_CH = 5;
	// per-channel register offsets; channel n sits at address {n, offset}
	localparam logic [3:0] OFS_COUNT = 4'h0;
	localparam logic [3:0] OFS_CCA = 4'h1;
	localparam logic [3:0] OFS_CCB = 4'h2;
	localparam logic [3:0] OFS_BUFA = 4'h3;
	localparam logic [3:0] OFS_BUFB = 4'h4;
	localparam logic [3:0] OFS_IOSEL = 4'h5;
	localparam logic [3:0] OFS_IEN = 4'h6;
	localparam logic [3:0] OFS_STATUS = 4'h7;
	// shared registers
	localparam logic [7:0] ADDR_START = 8'h50;
	localparam logic [7:0] ADDR_SYNC = 8'h51;
	localparam logic [7:0] ADDR_FUNC = 8'h52;
	localparam logic [7:0] ADDR_OUTCTL = 8'h53;
	// io_select_reg fields
	localparam int IO_A_CAP = 0;
	localparam int IO_B_CAP = 1;
	localparam int IO_CLR_LSB = 2;
	localparam logic [1:0] CLR_NONE = 2'h0;
	localparam logic [1:0] CLR_A = 2'h1;
	localparam logic [1:0] CLR_B = 2'h2;
	// status and enable bit positions
	localparam int FLAG_A = 0;
	localparam int FLAG_B = 1;
	localparam int FLAG_OVF = 2;
	// function_control_reg fields: bits 2:0 buffer enables, 4:3 combination mode
	localparam int FUNC_BUF_A3 = 0;
	localparam int FUNC_MODE_LSB = 3;
	localparam logic [1:0] COMBO_COMP = 2'h2;
	localparam logic [1:0] COMBO_RSYNC = 2'h3;
	// output_control_reg fields
	localparam int OUT_INV3 = 0;
	localparam int OUT_INV4 = 1;
	// count limits and reset value
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_MIN = 16'h0000;
	localparam logic [15:0] RESET_VAL = 16'h0000;
endpackage

// ==== hw/timer_unit.sv ====
// five-channel 16-bit timer with buffering, flags, requests and bus contention
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module timer_unit
	import timer_pkg::*;
(
	input wire logic clk_in, // 100 MHz system clock
	input wire logic rst_b_in, // asynchronous reset, active low
	input wire logic [7:0] addr_in, // register index
	input wire logic [15:0] wdata_in, // write data
	input wire logic [1:0] byte_en_in, // write byte lanes, 2'h3 = word
	input wire logic wr_strobe_in, // write strobe, one cycle
	input wire logic rd_strobe_in, // read strobe, one cycle
	output logic [15:0] rd_data_out, // read data, cycle after strobe
	input wire logic [4:0] count_tick_in, // per-channel timer clock pulse
	input wire logic [4:0] channel_pin_a_in, // pin A level, asynchronous
	input wire logic [4:0] channel_pin_b_in, // pin B level, asynchronous
	output logic [4:0] channel_pin_a_out, // pin A drive level
	output logic [4:0] channel_pin_a_oe_out, // pin A drive enable
	output logic [4:0] channel_pin_b_out, // pin B drive level
	output logic [4:0] channel_pin_b_oe_out, // pin B drive enable
	output logic [14:0] irq_out, // request per channel: A, B, overflow
	output logic [3:0] dma_req_out // dma trigger, channels 0-3 A only
);
	// whole block state in one record
	typedef struct packed {
		logic [4:0][15:0] cnt; // timer_count per channel
		logic [4:0][15:0] cca; // compare_capture_a
		logic [4:0][15:0] ccb; // compare_capture_b
		logic [2:0][15:0] bufr; // buffer_a ch3, buffer_b ch3, buffer_b ch4
		logic [4:0][3:0] io; // io_select_reg
		logic [4:0][2:0] ien; // request enables
		logic [4:0][2:0] flg; // timer_status_reg flags
		logic [4:0][2:0] seen; // flag read as 1 since it was set
		logic [4:0] run; // start_reg, count_run_bit per channel
		logic [4:0] sync; // synchronised channels
		logic [4:0] func; // function_control_reg
		logic [1:0] outc; // output_control_reg
		logic dir_down; // channels 3/4 counting down
		logic [4:0] pa; // pin A toggle state
		logic [4:0] pb; // pin B toggle state
		logic [4:0] sa1, sa2, sa3; // pin A synchroniser and edge stage
		logic [4:0] sb1, sb2, sb3; // pin B synchroniser and edge stage
		logic w2v, w3v; // write in T2, write in T3
		logic [7:0] w2a, w3a; // their addresses
		logic [15:0] w2d, w3d; // their data
		logic [1:0] w2b, w3b; // their byte lanes
		logic [15:0] rdata; // read data register
	} state_t;

	state_t st_reg; // registered state
	state_t st_next; // next state
	logic [4:0] tick, mat_a, mat_b, cap_a, cap_b, clr, ovf_evt, down_ch; // per-channel events
	logic comp, pwm_any, pwm_evt; // combination mode decode
	logic sync_wr; // synced count written this cycle
	logic [15:0] sync_val; // value spread to synced counters
	logic [2:0] fset, fclr; // scratch for flag update

	// true when the T3 write targets this channel register
	function automatic logic wr3(input state_t s, input int ch, input logic [3:0] ofs);
		return s.w3v && (s.w3a == {ch[3:0], ofs});
	endfunction

	// byte-lane merge of write data into an old value
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
		input logic [1:0] be);
		return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction

	// all next-state logic
	always_comb begin
		st_next = st_reg;
		sync_wr = 1'b0;
		sync_val = RESET_VAL;
		fset = 3'h0;
		fclr = 3'h0;
		// first stage feeds only the second; edges come from stages two and three
		st_next.sa1 = channel_pin_a_in;
		st_next.sa2 = st_reg.sa1;
		st_next.sa3 = st_reg.sa2;
		st_next.sb1 = channel_pin_b_in;
		st_next.sb2 = st_reg.sb1;
		st_next.sb3 = st_reg.sb2;
		// strobe cycle is T1; the write lands at the end of T3
		st_next.w2v = wr_strobe_in;
		st_next.w2a = addr_in;
		st_next.w2d = wdata_in;
		st_next.w2b = byte_en_in;
		st_next.w3v = st_reg.w2v;
		st_next.w3a = st_reg.w2a;
		st_next.w3d = st_reg.w2d;
		st_next.w3b = st_reg.w2b;
		comp = (st_reg.func[FUNC_MODE_LSB +: 2] == COMBO_COMP);
		pwm_any = st_reg.func[FUNC_MODE_LSB + 1];
		// per-channel counting, matching and capture
		for (int ch = 0; ch < NUM_CH; ch++) begin
			tick[ch] = count_tick_in[ch] && st_reg.run[ch];
			down_ch[ch] = st_reg.dir_down && comp && (ch >= 3);
			cap_a[ch] = st_reg.io[ch][IO_A_CAP] && st_reg.sa2[ch] && !st_reg.sa3[ch];
			cap_b[ch] = st_reg.io[ch][IO_B_CAP] && st_reg.sb2[ch] && !st_reg.sb3[ch];
			// match only as the count leaves the value; a T3 write to that compare register masks it
			mat_a[ch] = tick[ch] && !st_reg.io[ch][IO_A_CAP] && !wr3(st_reg, ch, OFS_CCA)
				&& (st_reg.cnt[ch] == st_reg.cca[ch]);
			mat_b[ch] = tick[ch] && !st_reg.io[ch][IO_B_CAP] && !wr3(st_reg, ch, OFS_CCB)
				&& (st_reg.cnt[ch] == st_reg.ccb[ch]);
			clr[ch] = ((st_reg.io[ch][IO_CLR_LSB +: 2] == CLR_A) && (mat_a[ch] || cap_a[ch]))
				|| ((st_reg.io[ch][IO_CLR_LSB +: 2] == CLR_B) && (mat_b[ch] || cap_b[ch]));
			// a capture clear at the top count is not an overflow
			ovf_evt[ch] = tick[ch] && !clr[ch]
				&& (st_reg.cnt[ch] == (down_ch[ch] ? CNT_MIN : CNT_MAX));
			// counter: clear, then T3 write, then T2 byte freeze, then tick
			if (clr[ch]) begin
				st_next.cnt[ch] = RESET_VAL;
			end else if (wr3(st_reg, ch, OFS_COUNT)) begin
				st_next.cnt[ch] = merge(st_reg.cnt[ch], st_reg.w3d, st_reg.w3b);
			end else if (st_reg.w2v && st_reg.w2a == {ch[3:0], OFS_COUNT}
				&& st_reg.w2b != 2'h3) begin
				st_next.cnt[ch] = st_reg.cnt[ch];
			end else if (tick[ch]) begin
				st_next.cnt[ch] = down_ch[ch] ? st_reg.cnt[ch] - 16'h0001
					: st_reg.cnt[ch] + 16'h0001;
			end
			// capture takes the pre-clear count and beats a T3 write
			if (cap_a[ch]) begin
				st_next.cca[ch] = st_reg.cnt[ch];
			end else if (wr3(st_reg, ch, OFS_CCA)) begin
				st_next.cca[ch] = merge(st_reg.cca[ch], st_reg.w3d, st_reg.w3b);
			end
			if (cap_b[ch]) begin
				st_next.ccb[ch] = st_reg.cnt[ch];
			end else if (wr3(st_reg, ch, OFS_CCB)) begin
				st_next.ccb[ch] = merge(st_reg.ccb[ch], st_reg.w3d, st_reg.w3b);
			end
			// pins toggle on their own compare match
			if (mat_a[ch]) begin
				st_next.pa[ch] = !st_reg.pa[ch];
			end
			if (mat_b[ch]) begin
				st_next.pb[ch] = !st_reg.pb[ch];
			end
			// mode and enable registers
			if (wr3(st_reg, ch, OFS_IOSEL)) begin
				st_next.io[ch] = st_reg.w3d[3:0];
			end
			if (wr3(st_reg, ch, OFS_IEN)) begin
				st_next.ien[ch] = st_reg.w3d[2:0];
			end
			// flags: a set in the clearing cycle survives
			fset[FLAG_A] = mat_a[ch] || cap_a[ch];
			fset[FLAG_B] = mat_b[ch] || cap_b[ch];
			// in complementary mode ch4 flags only the underflow
			fset[FLAG_OVF] = ovf_evt[ch] && !(comp && ch == 4 && !down_ch[ch]);
			fclr = wr3(st_reg, ch, OFS_STATUS) ? (~st_reg.w3d[2:0] & st_reg.seen[ch]) : 3'h0;
			st_next.flg[ch] = (st_reg.flg[ch] & ~fclr) | fset;
			st_next.seen[ch] = (st_reg.seen[ch] & ~fclr) & st_next.flg[ch];
			if (rd_strobe_in && addr_in == {ch[3:0], OFS_STATUS}) begin
				st_next.seen[ch] = (st_next.seen[ch] | st_reg.flg[ch]) & st_next.flg[ch];
			end
		end
		// buffer writes first so that captures below override them
		if (wr3(st_reg, 3, OFS_BUFA)) begin
			st_next.bufr[0] = merge(st_reg.bufr[0], st_reg.w3d, st_reg.w3b);
		end
		if (wr3(st_reg, 3, OFS_BUFB)) begin
			st_next.bufr[1] = merge(st_reg.bufr[1], st_reg.w3d, st_reg.w3b);
		end
		if (wr3(st_reg, 4, OFS_BUFB)) begin
			st_next.bufr[2] = merge(st_reg.bufr[2], st_reg.w3d, st_reg.w3b);
		end
		// buffer A of channel 3; capture push in every mode, compare copy only outside the pwm modes where A3 sets the period
		if (st_reg.func[FUNC_BUF_A3]) begin
			if (cap_a[3]) begin
				st_next.bufr[0] = st_reg.cca[3];
			end else if (mat_a[3] && !pwm_any) begin
				st_next.cca[3] = st_reg.bufr[0];
			end
		end
		// buffer B of channels 3 and 4
		pwm_evt = mat_a[3] || (comp && ovf_evt[4] && down_ch[4]);
		for (int ch = 3; ch < NUM_CH; ch++) begin
			if (st_reg.func[ch - 2]) begin
				if (cap_b[ch]) begin
					st_next.bufr[ch - 2] = st_reg.ccb[ch];
				end else if ((pwm_any ? pwm_evt : mat_b[ch]) && !wr3(st_reg, ch, OFS_CCB)) begin
					st_next.ccb[ch] = st_reg.bufr[ch - 2];
				end
			end
		end
		// count direction of the complementary pair
		if (!comp) begin
			st_next.dir_down = 1'b0;
		end else if (mat_a[3]) begin
			st_next.dir_down = 1'b1;
		end else if (ovf_evt[4] && down_ch[4]) begin
			st_next.dir_down = 1'b0;
		end
		// a write to one synchronised counter lands in all of them
		for (int ch = 0; ch < NUM_CH; ch++) begin
			if (wr3(st_reg, ch, OFS_COUNT) && st_reg.sync[ch]) begin
				sync_wr = 1'b1;
				sync_val = st_next.cnt[ch];
			end
		end
		for (int ch = 0; ch < NUM_CH; ch++) begin
			if (sync_wr && st_reg.sync[ch]) begin
				st_next.cnt[ch] = sync_val;
			end
		end
		// shared registers; mode changes are left to software discipline
		if (st_reg.w3v) begin
			unique case (st_reg.w3a)
				ADDR_START: st_next.run = st_reg.w3d[4:0];
				ADDR_SYNC: st_next.sync = st_reg.w3d[4:0];
				ADDR_FUNC: st_next.func = st_reg.w3d[4:0];
				ADDR_OUTCTL: st_next.outc = st_reg.w3d[1:0];
				default: ;
			endcase
		end
		// read mux from the current state, so a capture now is not yet seen
		st_next.rdata = 16'h0000;
		if (rd_strobe_in) begin
			for (int ch = 0; ch < NUM_CH; ch++) begin
				unique case (addr_in)
					{ch[3:0], OFS_COUNT}: st_next.rdata = st_reg.cnt[ch];
					{ch[3:0], OFS_CCA}: st_next.rdata = st_reg.cca[ch];
					{ch[3:0], OFS_CCB}: st_next.rdata = st_reg.ccb[ch];
					{ch[3:0], OFS_IOSEL}: st_next.rdata = {12'h000, st_reg.io[ch]};
					{ch[3:0], OFS_IEN}: st_next.rdata = {13'h0000, st_reg.ien[ch]};
					{ch[3:0], OFS_STATUS}: st_next.rdata = {13'h0000, st_reg.flg[ch]};
					default: ;
				endcase
			end
			unique case (addr_in)
				{4'h3, OFS_BUFA}: st_next.rdata = st_reg.bufr[0];
				{4'h3, OFS_BUFB}: st_next.rdata = st_reg.bufr[1];
				{4'h4, OFS_BUFB}: st_next.rdata = st_reg.bufr[2];
				ADDR_START: st_next.rdata = {11'h000, st_reg.run};
				ADDR_SYNC: st_next.rdata = {11'h000, st_reg.sync};
				ADDR_FUNC: st_next.rdata = {11'h000, st_reg.func};
				ADDR_OUTCTL: st_next.rdata = {14'h0000, st_reg.outc};
				default: ;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs: requests are flag AND enable; level inversion only in pwm modes
	always_comb begin
		for (int ch = 0; ch < NUM_CH; ch++) begin
			irq_out[ch * 3 +: 3] = st_reg.flg[ch] & st_reg.ien[ch];
		end
		for (int ch = 0; ch < 4; ch++) begin
			dma_req_out[ch] = st_reg.flg[ch][FLAG_A] && st_reg.ien[ch][FLAG_A];
		end
		channel_pin_a_out = st_reg.pa ^ {st_reg.outc[OUT_INV4] && pwm_any,
			st_reg.outc[OUT_INV3] && pwm_any, 3'h0};
		channel_pin_b_out = st_reg.pb ^ {st_reg.outc[OUT_INV4] && pwm_any,
			st_reg.outc[OUT_INV3] && pwm_any, 3'h0};
		for (int ch = 0; ch < NUM_CH; ch++) begin
			channel_pin_a_oe_out[ch] = !st_reg.io[ch][IO_A_CAP];
			channel_pin_b_oe_out[ch] = !st_reg.io[ch][IO_B_CAP];
		end
		rd_data_out = st_reg.rdata;
	end

	// checks on the block's own behaviour
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_word_write_cnt2;
		wr_strobe_in && addr_in == {4'h2, OFS_COUNT} && byte_en_in == 2'h3 ##2 tick[2];
	endsequence

	a_match_flag_set: assert property (mat_a[0] |=> st_reg.flg[0][FLAG_A])
		else $error("match A did not set its flag");
	a_cmp_buffer_copy: assert property (st_reg.func[FUNC_BUF_A3] && !pwm_any && mat_a[3]
		|=> st_reg.cca[3] == $past(st_reg.bufr[0]) && st_reg.pa[3] != $past(st_reg.pa[3]))
		else $error("compare buffer not copied on match");
	a_cap_buffer_push: assert property (st_reg.func[FUNC_BUF_A3] && cap_a[3]
		|=> st_reg.bufr[0] == $past(st_reg.cca[3]) && st_reg.cca[3] == $past(st_reg.cnt[3]))
		else $error("capture buffer push wrong");
	a_ovf_flag_set: assert property (ovf_evt[1] |=> st_reg.flg[1][FLAG_OVF])
		else $error("wrap did not set overflow flag");
	a_clear_beats_write: assert property (clr[2] && wr3(st_reg, 2, OFS_COUNT)
		|=> st_reg.cnt[2] == RESET_VAL)
		else $error("count write beat clear");
	a_word_write_wins: assert property (s_word_write_cnt2 ##0 !clr[2] && !st_reg.sync[2]
		|=> st_reg.cnt[2] == $past(st_reg.w3d))
		else $error("increment disturbed word write");
	// a B request of channel 3 may legally stand beside its dma request
	a_dma_needs_flag: assert property (dma_req_out[3] |-> st_reg.flg[3][FLAG_A]
		&& irq_out[9])
		else $error("dma request without A3 request");
	a_dma_a_only: assert property (dma_req_out == {irq_out[9], irq_out[6],
		irq_out[3], irq_out[0]})
		else $error("dma request not from an A request");
	a_capture_read_old: assert property (rd_strobe_in && addr_in == {4'h0, OFS_CCA}
		&& cap_a[0] |=> rd_data_out == $past(st_reg.cca[0]))
		else $error("read saw captured value");
	a_flag_clear_guard: assert property (st_reg.flg[0][FLAG_A] && !st_reg.seen[0][FLAG_A]
		&& !rd_strobe_in |=> st_reg.flg[0][FLAG_A])
		else $error("flag cleared without prior read");
	// contention on channel 1: a masked match must leave the pin alone
	a_write_masks_match: assert property (wr3(st_reg, 1, OFS_CCA) && tick[1]
		&& !st_reg.io[1][IO_A_CAP] && st_reg.cnt[1] == st_reg.cca[1]
		|=> st_reg.pa[1] == $past(st_reg.pa[1]))
		else $error("compare write did not mask the match");
	a_capture_beats_write: assert property (cap_b[1] && wr3(st_reg, 1, OFS_CCB)
		|=> st_reg.ccb[1] == $past(st_reg.cnt[1]))
		else $error("register write beat the capture");
	a_comp_buffer_b: assert property (comp && st_reg.func[1] && pwm_evt && !cap_b[3]
		&& !wr3(st_reg, 3, OFS_CCB) |=> st_reg.ccb[3] == $past(st_reg.bufr[1]))
		else $error("complementary buffer B not copied");
endmodule
`default_nettype wire

// ==== tb/test_timer_unit.sv ====
// self-checking bench for the five-channel timer
`timescale 1ns/1ps
`default_nettype none
module test_timer_unit;
	import timer_pkg::*;
	logic clk_in = 1'b0; // system clock
	logic rst_b_in = 1'b0; // reset, active low
	logic [7:0] addr_in = 8'h00;
	logic [15:0] wdata_in = 16'h0000;
	logic [1:0] byte_en_in = 2'h0;
	logic wr_strobe_in = 1'b0;
	logic rd_strobe_in = 1'b0;
	logic [4:0] count_tick_in = 5'h00;
	logic [4:0] channel_pin_a_in = 5'h00; // capture pins, driven by the bench
	logic [4:0] channel_pin_b_in = 5'h00;
	logic [15:0] rd_data_out;
	logic [4:0] pin_a, pin_a_oe, pin_b, pin_b_oe;
	logic [14:0] irq_out;
	logic [3:0] dma_req_out;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [15:0] exp_q[$]; // expected read data, oldest first
	string name_q[$];
	logic pend = 1'b0; // a read strobe was taken at the last edge
	logic [15:0] rv;
	logic p0;

	timer_unit u_timer_unit (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .byte_en_in(byte_en_in), .wr_strobe_in(wr_strobe_in),
		.rd_strobe_in(rd_strobe_in), .rd_data_out(rd_data_out),
		.count_tick_in(count_tick_in), .channel_pin_a_in(channel_pin_a_in),
		.channel_pin_b_in(channel_pin_b_in), .channel_pin_a_out(pin_a),
		.channel_pin_a_oe_out(pin_a_oe), .channel_pin_b_out(pin_b),
		.channel_pin_b_oe_out(pin_b_oe), .irq_out(irq_out), .dma_req_out(dma_req_out));

	always #5 clk_in = ~clk_in;

	// one comparison, counted and reported at once
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		comparisons++;
		if (got !== ex) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// read watcher: data stand only in the cycle after the strobe
	always @(posedge clk_in) begin
		if (pend && exp_q.size() > 0)
			chk(name_q.pop_front(), exp_q.pop_front(), rd_data_out);
		pend <= rd_strobe_in;
	end

	// hang guard, well above the expected run length
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			print_verdict();
		end
	end

	function automatic logic [7:0] ad(input int ch, input logic [3:0] ofs);
		return {ch[3:0], ofs};
	endfunction

	// bus write; tk ticks counters in T2 and T3 to provoke contention
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be = 2'h3,
		input logic [4:0] tk = 5'h00);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		byte_en_in <= be;
		wr_strobe_in <= 1'b1;
		@(posedge clk_in);
		wr_strobe_in <= 1'b0;
		count_tick_in <= tk;
		repeat (2) @(posedge clk_in);
		count_tick_in <= 5'h00;
		@(posedge clk_in);
	endtask

	// bus read; the expectation goes to the watcher's queue
	task automatic rd(input logic [7:0] a, input logic [15:0] ex, input string nm);
		@(posedge clk_in);
		addr_in <= a;
		rd_strobe_in <= 1'b1;
		exp_q.push_back(ex);
		name_q.push_back(nm);
		@(posedge clk_in);
		rd_strobe_in <= 1'b0;
	endtask

	// n single-cycle count pulses on one channel, then let flags land
	task automatic tick(input int ch, input int n);
		repeat (n) begin
			@(posedge clk_in);
			count_tick_in <= 5'h01 << ch;
			@(posedge clk_in);
			count_tick_in <= 5'h00;
		end
		repeat (3) @(posedge clk_in);
	endtask

	initial begin
		void'($urandom(21));
		repeat (2) @(posedge clk_in);
		rst_b_in <= 1'b1;
		rd(ad(0, OFS_COUNT), 16'h0000, "count0");
		rd(8'h5f, 16'h0000, "unmapped");
		wr(ADDR_START, 16'h001f); // every counter may run
		// overflow lands in T3 of a word write
		wr(ad(0, OFS_COUNT), 16'hfffe);
		wr(ad(0, OFS_COUNT), 16'h0005, 2'h3, 5'h01);
		rd(ad(0, OFS_COUNT), 16'h0005, "count0");
		rd(ad(0, OFS_STATUS), 16'h0004, "status0");
		wr(ad(0, OFS_IEN), 16'h0004);
		chk("irq", 16'h0004, {1'b0, irq_out});
		chk("dma", 16'h0000, {12'h000, dma_req_out});
		wr(ad(0, OFS_STATUS), 16'h0000);
		rd(ad(0, OFS_STATUS), 16'h0000, "status0");
		chk("irq", 16'h0000, {1'b0, irq_out});
		$display("test overflow done");
		// word and byte writes racing count pulses
		rv = {4'h1, 12'($urandom)};
		wr(ad(2, OFS_COUNT), rv, 2'h3, 5'h04);
		rd(ad(2, OFS_COUNT), rv, "count2");
		// the T2 tick met both compare registers at count 0; clear those flags
		rd(ad(2, OFS_STATUS), 16'h0003, "status2");
		wr(ad(2, OFS_STATUS), 16'h0000);
		wr(ad(2, OFS_COUNT), 16'hab00, 2'h2, 5'h04);
		rd(ad(2, OFS_COUNT), {8'hab, rv[7:0]}, "count2");
		wr(ADDR_SYNC, 16'h000c); // channels 2 and 3 synchronised
		wr(ad(2, OFS_COUNT), 16'h0055, 2'h1);
		rd(ad(3, OFS_COUNT), 16'hab55, "count3");
		wr(ADDR_SYNC, 16'h0000);
		$display("test count writes done");
		// clear on match A, period N+1 with N=2, on every channel
		for (int ch = 0; ch < NUM_CH; ch++) begin
			wr(ad(ch, OFS_CCB), 16'h8000);
			wr(ad(ch, OFS_CCA), 16'h0002);
			wr(ad(ch, OFS_IOSEL), 16'h0004);
			wr(ad(ch, OFS_COUNT), 16'h0000);
			wr(ad(ch, OFS_IEN), 16'h0001);
			tick(ch, 2);
			rd(ad(ch, OFS_STATUS), 16'h0000, "status");
			tick(ch, 1);
			rd(ad(ch, OFS_COUNT), 16'h0000, "count");
			rd(ad(ch, OFS_STATUS), 16'h0001, "status");
			chk("irq", 16'h0001 << (3 * ch), {1'b0, irq_out});
			chk("dma", (ch < 4) ? 16'h0001 << ch : 16'h0000, {12'h000, dma_req_out});
			wr(ad(ch, OFS_IEN), 16'h0000);
		end
		$display("test compare match done");
		// buffered compare on channel 3, none on channel 0
		wr(ADDR_FUNC, 16'h0001);
		wr(ad(3, OFS_IOSEL), 16'h0000);
		wr(ad(3, OFS_COUNT), 16'h0000);
		wr(ad(3, OFS_BUFA), 16'h0040);
		wr(ad(0, OFS_BUFA), 16'h0040);
		p0 = pin_a[3];
		tick(3, 3);
		rd(ad(3, OFS_CCA), 16'h0040, "cca3");
		chk("pin_a3", {15'h0000, ~p0}, {15'h0000, pin_a[3]});
		rd(ad(0, OFS_BUFA), 16'h0000, "bufa0");
		// buffered capture pushes the old capture value into the buffer
		wr(ad(3, OFS_BUFA), 16'h0099);
		rd(ad(3, OFS_STATUS), 16'h0001, "status3");
		wr(ad(3, OFS_STATUS), 16'h0000);
		wr(ad(3, OFS_IOSEL), 16'h0001);
		wr(ad(3, OFS_COUNT), 16'h0077);
		channel_pin_a_in <= 5'h08;
		repeat (6) @(posedge clk_in);
		rd(ad(3, OFS_CCA), 16'h0077, "cca3");
		rd(ad(3, OFS_BUFA), 16'h0040, "bufa3");
		rd(ad(3, OFS_STATUS), 16'h0001, "status3");
		$display("test buffering done");
		// T3 contention: clear beats count write, compare write masks match
		wr(ad(2, OFS_COUNT), 16'h0001);
		wr(ad(2, OFS_COUNT), 16'h1234, 2'h3, 5'h04);
		rd(ad(2, OFS_COUNT), 16'h0000, "count2");
		wr(ad(1, OFS_COUNT), 16'h0001);
		wr(ad(1, OFS_CCA), 16'h0005, 2'h3, 5'h02);
		rd(ad(1, OFS_COUNT), 16'h0003, "count1");
		rd(ad(1, OFS_CCA), 16'h0005, "cca1");
		// pin B1 rises with the strobe, so the capture lands in T3 of the write
		wr(ad(1, OFS_IOSEL), 16'h0002);
		fork
			wr(ad(1, OFS_CCB), 16'h1111);
			begin
				@(posedge clk_in);
				channel_pin_b_in <= 5'h02;
			end
		join
		rd(ad(1, OFS_CCB), 16'h0003, "ccb1");
		// pin A0 rises two edges before the read strobe, so both meet
		wr(ad(0, OFS_IOSEL), 16'h0001);
		wr(ad(0, OFS_COUNT), 16'h0033);
		channel_pin_a_in <= 5'h09;
		@(posedge clk_in);
		rd(ad(0, OFS_CCA), 16'h0002, "cca0");
		rd(ad(0, OFS_CCA), 16'h0033, "cca0");
		$display("test contention done");
		// level inversion; counters 3 and 4 halted before the mode change
		wr(ADDR_START, 16'h0007);
		wr(ADDR_FUNC, 16'({COMBO_RSYNC, 3'h0}));
		wr(ad(3, OFS_IOSEL), 16'h0000);
		p0 = pin_a[3];
		wr(ADDR_OUTCTL, 16'h0001);
		chk("pin_a3", {15'h0000, ~p0}, {15'h0000, pin_a[3]});
		wr(ADDR_OUTCTL, 16'h0000);
		chk("pin_a3", {15'h0000, p0}, {15'h0000, pin_a[3]});
		repeat (3) @(posedge clk_in);
		$display("test inversion done");
		// complementary pair, still halted: back to normal first, then switch
		wr(ADDR_FUNC, 16'h0000);
		wr(ad(3, OFS_CCA), 16'h0002);
		wr(ad(3, OFS_COUNT), 16'h0002);
		wr(ad(4, OFS_IOSEL), 16'h0000);
		wr(ad(3, OFS_BUFB), 16'h0abc);
		wr(ADDR_FUNC, 16'({COMBO_COMP, 3'h2}));
		wr(ADDR_START, 16'h001f);
		tick(3, 1);
		rd(ad(3, OFS_CCB), 16'h0abc, "ccb3");
		wr(ad(3, OFS_BUFB), 16'h0def);
		tick(4, 1);
		rd(ad(3, OFS_CCB), 16'h0def, "ccb3");
		rd(ad(4, OFS_COUNT), 16'hffff, "count4");
		rd(ad(4, OFS_STATUS), 16'h0005, "status4");
		$display("test complementary done");
		print_verdict();
	end
endmodule
`default_nettype wire
